//--- src/evl_top.sv
// Event input function mapping with APB registers and set point limiter.
// Assumes event inputs synchronous to pclk and an APB master on the bus.
//
// Overview of operation
// - An input assigned to action inversion flips the configured direct/reverse action while on.
// - An input assigned to set point source selects the remote set point while on, else local.
// - The remote set point indicator is on while remote set point mode is in effect.
// - An input assigned to full tuning starts the 100% run on turning on and cancels it on off.
// - An input assigned to partial tuning starts the 40% run on turning on and cancels it on off; it has no effect while the config heat/cool bit is set.
// - An input assigned to setting lock refuses setting changes while on.
// - An input assigned to comm write control enables communications writes only while on.
// - An input assigned to latch clearing clears all six alarm latches when it turns on.
// - Each of the six inputs has its own function assignment field.
// - A new set point is taken only when it lies within the lower and upper bounds.
// - A bound change that leaves the set point outside forces it to the violated bound.
// - A change of input type, unit or either scaling bound resets both bounds to the scale.
// - An input level change counts only after holding for 50 ms.
// - Set point number bits with no assigned input read as off.
//
// Added by the designer: the APB interface to the registers and the address map.
`include "evl_params.svh"
`default_nettype none

module evl_top #(
    parameter int FILTER_CYCLES = `EVL_FILTER_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`EVL_ADDR_W-1:0] paddr,
    input wire logic [`EVL_DATA_W-1:0] pwdata,
    output logic [`EVL_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event contacts
    input wire logic [`EVL_NUM_INPUTS-1:0] event_in,
    // Set point
    input wire evl_pkg::evl_val_t remote_sp_value,
    output evl_pkg::evl_val_t active_sp,
    output logic remote_sp_lamp,
    output logic [`EVL_MSP_BITS-1:0] sp_number,
    // Control functions
    output logic action_direct,
    output logic full_tune_start,
    output logic full_tune_cancel,
    output logic partial_tune_start,
    output logic partial_tune_cancel,
    output logic setting_lock,
    output logic comm_write_enable,
    output logic [`EVL_ALARM_COUNT-1:0] alarm_latch_clear
);
    import evl_pkg::*;

    logic [`EVL_NUM_INPUTS-1:0] ev_level;
    evl_assign_t input_function_assign;
    logic [`EVL_CFG_W-1:0] config_q;
    logic [`EVL_INPUT_W-1:0] input_q;
    evl_val_t scale_hi_q;
    evl_val_t scale_lo_q;
    logic rescale_q;
    logic full_q;
    logic part_q;
    logic latch_q;
    logic remote_q;
    logic invert_q;
    evl_status_t status;

    evl_lim_if lim ();

    evl_debounce #(
        .FILTER_CYCLES(FILTER_CYCLES)
    ) u_debounce (
        .pclk(pclk),
        .presetn(presetn),
        .raw(event_in),
        .level(ev_level)
    );

    evl_limiter u_limiter (
        .pclk(pclk),
        .presetn(presetn),
        .lk(lim)
    );

    // Level of one function over all inputs assigned to it
    function automatic logic func_on(input evl_assign_t asg,
                                     input logic [`EVL_NUM_INPUTS-1:0] lvl,
                                     input evl_func_t f);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `EVL_NUM_INPUTS; i++) begin
            hit = hit | ((asg[i] == f) & lvl[i]);
        end
        return hit;
    endfunction

    logic invert_on;
    logic remote_on;
    logic full_on;
    logic part_on;
    logic lock_on;
    logic comm_on;
    logic latch_on;
    logic [`EVL_MSP_BITS-1:0] msp_on;

    assign invert_on = func_on(input_function_assign, ev_level, EVL_FN_INVERT);
    assign remote_on = func_on(input_function_assign, ev_level, EVL_FN_SP_SOURCE);
    assign full_on = func_on(input_function_assign, ev_level, EVL_FN_FULL_TUNE);
    assign part_on = func_on(input_function_assign, ev_level, EVL_FN_PART_TUNE)
                     & ~config_q[`EVL_CFG_HEAT_COOL];
    assign lock_on = func_on(input_function_assign, ev_level, EVL_FN_LOCK);
    assign comm_on = func_on(input_function_assign, ev_level, EVL_FN_COMM);
    assign latch_on = func_on(input_function_assign, ev_level, EVL_FN_LATCH);
    assign msp_on[0] = func_on(input_function_assign, ev_level, EVL_FN_MSP0);
    assign msp_on[1] = func_on(input_function_assign, ev_level, EVL_FN_MSP1);
    assign msp_on[2] = func_on(input_function_assign, ev_level, EVL_FN_MSP2);

    // APB decode
    logic setup;
    logic access;
    logic sel_assign;
    logic sel_config;
    logic sel_sp;
    logic sel_upper;
    logic sel_lower;
    logic sel_input;
    logic sel_scale_hi;
    logic sel_scale_lo;
    logic mapped;
    logic writable;
    logic scale_bad;
    logic wr_ok;
    logic commit;
    evl_val_t wval;
    logic [`EVL_DATA_W-1:0] rd_word;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = 1'b1;
    assign wval = pwdata[`EVL_VAL_W-1:0];

    always_comb begin
        sel_assign = 1'b0;
        sel_config = 1'b0;
        sel_sp = 1'b0;
        sel_upper = 1'b0;
        sel_lower = 1'b0;
        sel_input = 1'b0;
        sel_scale_hi = 1'b0;
        sel_scale_lo = 1'b0;
        mapped = 1'b1;
        if (paddr == `EVL_OFS_ASSIGN) begin
            sel_assign = 1'b1;
        end else if (paddr == `EVL_OFS_CONFIG) begin
            sel_config = 1'b1;
        end else if (paddr == `EVL_OFS_SP) begin
            sel_sp = 1'b1;
        end else if (paddr == `EVL_OFS_UPPER) begin
            sel_upper = 1'b1;
        end else if (paddr == `EVL_OFS_LOWER) begin
            sel_lower = 1'b1;
        end else if (paddr == `EVL_OFS_INPUT) begin
            sel_input = 1'b1;
        end else if (paddr == `EVL_OFS_SCALE_HI) begin
            sel_scale_hi = 1'b1;
        end else if (paddr == `EVL_OFS_SCALE_LO) begin
            sel_scale_lo = 1'b1;
        end else if (paddr != `EVL_OFS_STATUS && paddr != `EVL_OFS_EVENTS) begin
            mapped = 1'b0;
        end
    end

    assign writable = sel_assign | sel_config | sel_sp | sel_upper | sel_lower
                      | sel_input | sel_scale_hi | sel_scale_lo;
    assign scale_bad = (sel_scale_hi & (wval < scale_lo_q))
                       | (sel_scale_lo & (wval > scale_hi_q));
    assign wr_ok = access & pwrite & writable & ~setting_lock;
    assign commit = wr_ok & ~scale_bad & ~lim.reject;
    assign pslverr = access & (~mapped
                     | (pwrite & ~writable)
                     | (pwrite & writable & setting_lock)
                     | (pwrite & (scale_bad | lim.reject)));

    // Limiter strobes
    assign lim.wr_sp = wr_ok & sel_sp;
    assign lim.wr_upper = wr_ok & sel_upper;
    assign lim.wr_lower = wr_ok & sel_lower;
    assign lim.wdata = wval;
    assign lim.rescale = rescale_q;
    assign lim.range_hi = scale_hi_q;
    assign lim.range_lo = scale_lo_q;

    // Settings registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_function_assign <= evl_assign_t'(`EVL_RST_ASSIGN);
            config_q <= `EVL_RST_CONFIG;
            input_q <= `EVL_RST_INPUT;
            scale_hi_q <= `EVL_RST_UPPER;
            scale_lo_q <= `EVL_RST_LOWER;
        end else if (commit) begin
            if (sel_assign) begin
                input_function_assign <= evl_assign_t'(pwdata[`EVL_ASSIGN_W-1:0]);
            end
            if (sel_config) begin
                config_q <= pwdata[`EVL_CFG_W-1:0];
            end
            if (sel_input) begin
                input_q <= pwdata[`EVL_INPUT_W-1:0];
            end
            if (sel_scale_hi) begin
                scale_hi_q <= wval;
            end
            if (sel_scale_lo) begin
                scale_lo_q <= wval;
            end
        end
    end

    // Bound reset after a range change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rescale_q <= 1'b0;
        end else begin
            rescale_q <= commit & ((sel_input & (pwdata[`EVL_INPUT_W-1:0] != input_q))
                         | (sel_scale_hi & (wval != scale_hi_q))
                         | (sel_scale_lo & (wval != scale_lo_q)));
        end
    end

    // Read data
    always_comb begin
        status.remote = remote_q;
        status.invert = invert_q;
        status.action_direct = action_direct;
        status.full_tune_active = full_q;
        status.partial_tune_active = part_q;
        status.setting_lock = setting_lock;
        status.comm_write_enable = comm_write_enable;
        status.sp_number = sp_number;
        rd_word = '0;
        if (sel_assign) begin
            rd_word[`EVL_ASSIGN_W-1:0] = input_function_assign;
        end else if (sel_config) begin
            rd_word[`EVL_CFG_W-1:0] = config_q;
        end else if (sel_sp) begin
            rd_word[`EVL_VAL_W-1:0] = lim.sp;
        end else if (sel_upper) begin
            rd_word[`EVL_VAL_W-1:0] = lim.upper;
        end else if (sel_lower) begin
            rd_word[`EVL_VAL_W-1:0] = lim.lower;
        end else if (sel_input) begin
            rd_word[`EVL_INPUT_W-1:0] = input_q;
        end else if (sel_scale_hi) begin
            rd_word[`EVL_VAL_W-1:0] = scale_hi_q;
        end else if (sel_scale_lo) begin
            rd_word[`EVL_VAL_W-1:0] = scale_lo_q;
        end else if (paddr == `EVL_OFS_STATUS) begin
            rd_word[$bits(evl_status_t)-1:0] = status;
        end else if (paddr == `EVL_OFS_EVENTS) begin
            rd_word[`EVL_NUM_INPUTS-1:0] = ev_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup & ~pwrite) begin
            prdata <= rd_word;
        end
    end

    // Function levels and edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_q <= 1'b0;
            part_q <= 1'b0;
            latch_q <= 1'b0;
            full_tune_start <= 1'b0;
            full_tune_cancel <= 1'b0;
            partial_tune_start <= 1'b0;
            partial_tune_cancel <= 1'b0;
            alarm_latch_clear <= '0;
        end else begin
            full_q <= full_on;
            part_q <= part_on;
            latch_q <= latch_on;
            full_tune_start <= full_on & ~full_q;
            full_tune_cancel <= ~full_on & full_q;
            partial_tune_start <= part_on & ~part_q;
            partial_tune_cancel <= ~part_on & part_q;
            alarm_latch_clear <= {`EVL_ALARM_COUNT{latch_on & ~latch_q}};
        end
    end

    // Level outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_q <= 1'b0;
            invert_q <= 1'b0;
            action_direct <= 1'b0;
            remote_sp_lamp <= 1'b0;
            active_sp <= `EVL_RST_SP;
            sp_number <= '0;
            setting_lock <= 1'b0;
            comm_write_enable <= 1'b0;
        end else begin
            remote_q <= remote_on;
            invert_q <= invert_on;
            action_direct <= config_q[`EVL_CFG_DIRECT] ^ invert_on;
            remote_sp_lamp <= remote_on;
            active_sp <= remote_on ? remote_sp_value : lim.sp;
            sp_number <= msp_on;
            setting_lock <= lock_on;
            comm_write_enable <= comm_on;
        end
    end
endmodule

`default_nettype wire

//--- common/evl_params.svh
// Constants for the event input and set point limiter block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef EVL_PARAMS_SVH
`define EVL_PARAMS_SVH

`define EVL_NUM_INPUTS 6
`define EVL_CODE_W 4
`define EVL_VAL_W 16
`define EVL_INPUT_W 9
`define EVL_ADDR_W 8
`define EVL_DATA_W 32
`define EVL_ASSIGN_W 24
`define EVL_ALARM_COUNT 6
`define EVL_MSP_BITS 3
`define EVL_CNT_W 23

// Register byte offsets
`define EVL_OFS_ASSIGN 8'h00
`define EVL_OFS_CONFIG 8'h04
`define EVL_OFS_SP 8'h08
`define EVL_OFS_UPPER 8'h0c
`define EVL_OFS_LOWER 8'h10
`define EVL_OFS_INPUT 8'h14
`define EVL_OFS_SCALE_HI 8'h18
`define EVL_OFS_SCALE_LO 8'h1c
`define EVL_OFS_STATUS 8'h20
`define EVL_OFS_EVENTS 8'h24

// Config fields
`define EVL_CFG_DIRECT 0
`define EVL_CFG_HEAT_COOL 1
`define EVL_CFG_W 2

// Input function codes
`define EVL_CODE_NONE 4'h0
`define EVL_CODE_INVERT 4'h4
`define EVL_CODE_SP_SOURCE 4'h5
`define EVL_CODE_FULL_TUNE 4'h6
`define EVL_CODE_PART_TUNE 4'h7
`define EVL_CODE_LOCK 4'h8
`define EVL_CODE_COMM 4'h9
`define EVL_CODE_LATCH 4'ha
`define EVL_CODE_MSP0 4'hb
`define EVL_CODE_MSP1 4'hc
`define EVL_CODE_MSP2 4'hd

// Reset values
`define EVL_RST_UPPER 16'h0514
`define EVL_RST_LOWER 16'hff38
`define EVL_RST_SP 16'h0000
`define EVL_RST_INPUT 9'h000
`define EVL_RST_CONFIG 2'h0
`define EVL_RST_ASSIGN 24'h000000

// Input filter time
`define EVL_FILTER_MS 50
`define EVL_CLK_KHZ 125000
`define EVL_FILTER_CYCLES (`EVL_FILTER_MS * `EVL_CLK_KHZ)

`endif

//--- common/evl_pkg.sv
// Types shared by the event input and set point limiter block.
// Assumes evl_params.svh is on the include path.
`include "evl_params.svh"
`default_nettype none

package evl_pkg;
    typedef logic signed [`EVL_VAL_W-1:0] evl_val_t;

    typedef enum logic [`EVL_CODE_W-1:0] {
        EVL_FN_NONE = `EVL_CODE_NONE,
        EVL_FN_INVERT = `EVL_CODE_INVERT,
        EVL_FN_SP_SOURCE = `EVL_CODE_SP_SOURCE,
        EVL_FN_FULL_TUNE = `EVL_CODE_FULL_TUNE,
        EVL_FN_PART_TUNE = `EVL_CODE_PART_TUNE,
        EVL_FN_LOCK = `EVL_CODE_LOCK,
        EVL_FN_COMM = `EVL_CODE_COMM,
        EVL_FN_LATCH = `EVL_CODE_LATCH,
        EVL_FN_MSP0 = `EVL_CODE_MSP0,
        EVL_FN_MSP1 = `EVL_CODE_MSP1,
        EVL_FN_MSP2 = `EVL_CODE_MSP2
    } evl_func_t;

    typedef evl_func_t [`EVL_NUM_INPUTS-1:0] evl_assign_t;

    typedef struct packed {
        logic [`EVL_MSP_BITS-1:0] sp_number;
        logic comm_write_enable;
        logic setting_lock;
        logic partial_tune_active;
        logic full_tune_active;
        logic action_direct;
        logic invert;
        logic remote;
    } evl_status_t;
endpackage

`default_nettype wire

//--- common/evl_lim_if.sv
// Link between the register front end and the set point limiter.
// Assumes both ends share pclk; strobes are single-cycle.
`include "evl_params.svh"
`default_nettype none

interface evl_lim_if;
    import evl_pkg::*;
    logic wr_sp;
    logic wr_upper;
    logic wr_lower;
    logic rescale;
    evl_val_t wdata;
    evl_val_t range_hi;
    evl_val_t range_lo;
    evl_val_t sp;
    evl_val_t upper;
    evl_val_t lower;
    logic reject;

    modport ctrl (
        output wr_sp, wr_upper, wr_lower, rescale, wdata, range_hi, range_lo,
        input sp, upper, lower, reject
    );
    modport lim (
        input wr_sp, wr_upper, wr_lower, rescale, wdata, range_hi, range_lo,
        output sp, upper, lower, reject
    );
endinterface

`default_nettype wire

//--- src/evl_debounce.sv
// Per-input filter: a level change is taken only after it has held steadily.
// Assumes raw inputs already synchronous to pclk.
`include "evl_params.svh"
`default_nettype none

module evl_debounce #(
    parameter int FILTER_CYCLES = `EVL_FILTER_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw and filtered levels
    input wire logic [`EVL_NUM_INPUTS-1:0] raw,
    output logic [`EVL_NUM_INPUTS-1:0] level
);
    localparam logic [`EVL_CNT_W-1:0] LAST = `EVL_CNT_W'(FILTER_CYCLES - 1);

    logic [`EVL_CNT_W-1:0] cnt [`EVL_NUM_INPUTS];

    // Hold-time counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= '0;
            for (int i = 0; i < `EVL_NUM_INPUTS; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `EVL_NUM_INPUTS; i++) begin
                if (raw[i] == level[i]) begin
                    cnt[i] <= '0;
                end else if (cnt[i] >= LAST) begin
                    level[i] <= raw[i];
                    cnt[i] <= '0;
                end else begin
                    cnt[i] <= cnt[i] + `EVL_CNT_W'(1);
                end
            end
        end
    end
endmodule

`default_nettype wire

//--- src/evl_limiter.sv
// Set point limiter: holds the set point and its two bounds.
// Assumes at most one strobe per cycle; refused strobes change nothing.
`include "evl_params.svh"
`default_nettype none

module evl_limiter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Front end link
    evl_lim_if.lim lk
);
    import evl_pkg::*;

    evl_val_t next_sp;
    evl_val_t next_upper;
    evl_val_t next_lower;

    function automatic evl_val_t clamp(input evl_val_t v, input evl_val_t lo, input evl_val_t hi);
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return lo;
        end
        return v;
    endfunction

    // Acceptance and clamping
    always_comb begin
        lk.reject = 1'b0;
        next_upper = lk.upper;
        next_lower = lk.lower;
        next_sp = lk.sp;
        if (lk.rescale) begin
            next_upper = lk.range_hi;
            next_lower = lk.range_lo;
        end else if (lk.wr_upper) begin
            if (lk.wdata < lk.lower) begin
                lk.reject = 1'b1;
            end else begin
                next_upper = lk.wdata;
            end
        end else if (lk.wr_lower) begin
            if (lk.wdata > lk.upper) begin
                lk.reject = 1'b1;
            end else begin
                next_lower = lk.wdata;
            end
        end else if (lk.wr_sp) begin
            if (lk.wdata > lk.upper || lk.wdata < lk.lower) begin
                lk.reject = 1'b1;
            end else begin
                next_sp = lk.wdata;
            end
        end
        next_sp = clamp(next_sp, next_lower, next_upper);
    end

    // Stored values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lk.sp <= `EVL_RST_SP;
            lk.upper <= `EVL_RST_UPPER;
            lk.lower <= `EVL_RST_LOWER;
        end else begin
            lk.sp <= next_sp;
            lk.upper <= next_upper;
            lk.lower <= next_lower;
        end
    end
endmodule

`default_nettype wire

//--- bench/evl_top_assertions.sv
// Port checker for the event input block and its set point limiter.
// Assumes binding onto evl_top; sees its ports only.
`include "evl_params.svh"
`default_nettype none

module evl_top_assertions (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pslverr,
    // Set point
    input wire evl_pkg::evl_val_t remote_sp_value,
    input wire evl_pkg::evl_val_t active_sp,
    input wire logic remote_sp_lamp,
    // Functions
    input wire logic full_tune_start,
    input wire logic full_tune_cancel,
    input wire logic partial_tune_start,
    input wire logic partial_tune_cancel,
    input wire logic setting_lock,
    input wire logic [`EVL_ALARM_COUNT-1:0] alarm_latch_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    import evl_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence access_s;
        psel && penable;
    endsequence
    sequence write_s;
        access_s ##0 pwrite;
    endsequence

    chk_lock_refuses_write: assert property ((setting_lock ##0 write_s) |-> pslverr)
        else $error("write accepted while locked");
    chk_error_in_access: assert property (pslverr |-> access_s)
        else $error("error outside access phase");
    chk_remote_follows: assert property (
        remote_sp_lamp && $past(remote_sp_lamp) |-> active_sp == $past(remote_sp_value))
        else $error("active set point not remote");
    chk_full_start_once: assert property (
        full_tune_start |-> !full_tune_cancel ##1 !full_tune_start)
        else $error("full tune start not one pulse");
    chk_full_cancel_once: assert property (full_tune_cancel |=> !full_tune_cancel)
        else $error("full tune cancel not one pulse");
    chk_part_start_once: assert property (
        partial_tune_start |-> !partial_tune_cancel ##1 !partial_tune_start)
        else $error("partial tune start not one pulse");
    chk_part_cancel_once: assert property (partial_tune_cancel |=> !partial_tune_cancel)
        else $error("partial tune cancel not one pulse");
    chk_latch_all_clear: assert property (
        alarm_latch_clear != 6'h00 |-> alarm_latch_clear == 6'h3f ##1 alarm_latch_clear == 6'h00)
        else $error("latch clear not all six for one cycle");
endmodule

bind evl_top evl_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr,
    .remote_sp_value, .active_sp, .remote_sp_lamp, .full_tune_start, .full_tune_cancel,
    .partial_tune_start, .partial_tune_cancel, .setting_lock, .alarm_latch_clear);

`default_nettype wire

//--- bench/evl_contacts.sv
// Model of the external contacts on the event inputs.
// Assumes levels change right after a pclk edge; bounce flips bits briefly.
`include "evl_params.svh"
`default_nettype none

module evl_contacts (
    // Clock
    input wire logic pclk,
    // Wanted contact state and bounce mask
    input wire logic [`EVL_NUM_INPUTS-1:0] want,
    input wire logic [`EVL_NUM_INPUTS-1:0] bounce,
    // Contact levels
    output logic [`EVL_NUM_INPUTS-1:0] event_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contacts settle one edge after the request; bounce inverts the steady level
    always @(posedge pclk) begin
        event_in <= want ^ bounce;
    end
endmodule

`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the event input block and set point limiter.
// Drives APB and the contact model; expected results wait in a queue.
`include "evl_params.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import evl_pkg::*;
    localparam int FC = 4;
    typedef struct {logic [31:0] d; logic e; logic rd;} evl_note_t;
    evl_note_t notes[$];
    int miscompares = 0;
    int checks = 0;
    int fs = 0, fc = 0, ps = 0, pc = 0, lc = 0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [5:0] want = 6'h00, bounce = 6'h00, event_in;
    evl_val_t remote_sp_value = 16'h0000, active_sp;
    logic remote_sp_lamp, action_direct, full_tune_start, full_tune_cancel;
    logic partial_tune_start, partial_tune_cancel, setting_lock, comm_write_enable;
    logic [2:0] sp_number;
    logic [5:0] alarm_latch_clear;
    logic [15:0] rs = 16'h66e3;

    evl_top #(.FILTER_CYCLES(FC)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .event_in, .remote_sp_value, .active_sp,
        .remote_sp_lamp, .sp_number, .action_direct, .full_tune_start, .full_tune_cancel,
        .partial_tune_start, .partial_tune_cancel, .setting_lock, .comm_write_enable,
        .alarm_latch_clear);
    evl_contacts u_contacts (.pclk, .want, .bounce, .event_in);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One APB transfer; d is write data or the expected read data
    task automatic apb(input int w, input logic [7:0] a, input logic [31:0] d, input int e);
        notes.push_back('{d, e[0], w == 0 && e == 0});
        psel <= 1'b1;
        pwrite <= w[0];
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    initial begin
        forever #4 pclk = ~pclk;
    end

    // Result monitor and pulse counters
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            check({31'h0, pslverr}, {31'h0, notes[0].e});
            if (notes[0].rd) check(prdata, notes[0].d);
            void'(notes.pop_front());
        end
        fs <= fs + int'(full_tune_start);
        fc <= fc + int'(full_tune_cancel);
        ps <= ps + int'(partial_tune_start);
        pc <= pc + int'(partial_tune_cancel);
        lc <= lc + int'(alarm_latch_clear == 6'h3f);
        rs <= lfsr(rs);
        remote_sp_value <= rs;
    end

    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        summarize();
    end

    initial begin
        logic [31:0] v;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 8'h0c, 32'h514, 0);
        apb(0, 8'h10, 32'hff38, 0);
        apb(0, 8'h08, 32'h0, 0);
        apb(0, 8'h00, 32'h0, 0);
        apb(0, 8'h28, 32'h0, 1);
        apb(1, 8'h20, 32'h1, 1);
        apb(1, 8'h08, 32'h7d0, 1);
        apb(1, 8'h08, 32'h64, 0);
        apb(1, 8'h0c, 32'h32, 0);
        apb(0, 8'h08, 32'h32, 0);
        apb(1, 8'h10, 32'h3c, 1);
        apb(1, 8'h0c, 32'h50, 0);
        apb(1, 8'h10, 32'h46, 0);
        apb(0, 8'h08, 32'h46, 0);
        apb(1, 8'h18, 32'h3e8, 0);
        repeat (2) @(posedge pclk);
        apb(0, 8'h0c, 32'h3e8, 0);
        apb(0, 8'h10, 32'hff38, 0);
        apb(1, 8'h0c, 32'h1f4, 0);
        apb(1, 8'h14, 32'h5, 0);
        repeat (2) @(posedge pclk);
        apb(0, 8'h0c, 32'h3e8, 0);
        for (int i = 0; i < 4; i++) begin
            v = {23'h0, rs[8:0]};
            apb(1, 8'h08, v, 0);
            apb(0, 8'h08, v, 0);
        end
        apb(1, 8'h00, 32'ha97654, 0);
        want <= 6'h3f;
        repeat (FC + 4) @(posedge pclk);
        check({31'h0, remote_sp_lamp}, 32'h1);
        check({31'h0, action_direct}, 32'h1);
        check({31'h0, comm_write_enable}, 32'h1);
        apb(0, 8'h20, 32'h5f, 0);
        want <= 6'h00;
        repeat (FC + 4) @(posedge pclk);
        apb(0, 8'h20, 32'h0, 0);
        bounce <= 6'h3f;
        repeat (FC - 1) @(posedge pclk);
        bounce <= 6'h00;
        repeat (FC + 4) @(posedge pclk);
        check(fs, 1);
        check(fc, 1);
        check(ps, 1);
        check(pc, 1);
        check(lc, 1);
        apb(1, 8'h04, 32'h3, 0);
        apb(0, 8'h04, 32'h3, 0);
        apb(1, 8'h00, 32'h0b0008, 0);
        want <= 6'h11;
        repeat (FC + 4) @(posedge pclk);
        check({29'h0, sp_number}, 32'h1);
        apb(0, 8'h24, 32'h11, 0);
        apb(0, 8'h20, 32'ha4, 0);
        apb(1, 8'h08, 32'ha, 1);
        apb(1, 8'h00, 32'h0, 1);
        want <= 6'h00;
        repeat (FC + 4) @(posedge pclk);
        apb(1, 8'h08, 32'ha, 0);
        repeat (2) @(posedge pclk);
        check({16'h0, active_sp}, 32'ha);
        summarize();
    end
endmodule

`default_nettype wire
